// file: hdl/lbs_indicator.v
// LED and buzzer status indicator for a wireless power transmitter.
// Assumes the operating state arrives as a synchronous code and the
// shared converter answers a sample request with a done pulse.
//
// How it works
// - Slow blink: one second lit, one second dark, repeating.
// - Fast blink: 400 ms lit, 800 ms dark, repeating.
// - Configuration voltage sampled once after power-on, then latched.
// - Green: slow blink in transfer, lit at complete, dark in fault/warning.
// - Red: dark in transfer/complete, lit in fault, fast blink in warning.
// - Standby option lights both LEDs until another state is entered.
// - Ten options; first five light standby, last five dark; two supported.
// - Buzzer toggles at 2 kHz while sounding, holds low when silent.
// - Entering transfer sounds one 400 ms tone.
// - Transfer tone starts within 500 ms of entering transfer.
// - Transfer tone coincides with the green LED change within 250 ms.
// - Warning sequence starts when foreign-object warning state is entered.
// - Warning: 30 s of 400/800 ms tones, then 30 s silent.
// - Warning cycle repeats while the condition lasts, stops when cleared.
// - Warning tones align with red lit, silences with red dark.
// - Red keeps fast blinking through the silent warning phase.
// - Configuration and thermistor inputs go through one muxed converter.
// - Spare indicator outputs held inactive.
`timescale 1ns/1ps
`include "lbs_consts.vh"

module lbs_indicator (
   // Clock and reset
   input wire clk_in,
   input wire arst_n_in,
   // Operating state from the transmitter controller
   input wire [2:0] op_state_in,
   // Shared converter
   input wire adc_done_in,
   input wire [9:0] adc_data_in,
   output reg adc_start_out,
   output reg [1:0] adc_channel_out,
   // Thermistor reading passed on
   output reg [9:0] thermistor_sense_out,
   // Lamp and buzzer pins
   output reg red_indicator_out,
   output reg green_indicator_out,
   output reg buzzer_out,
   output reg spare_indicator_c_out,
   output reg spare_indicator_d_out,
   // Latched option for observation
   output reg [3:0] led_option_out
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   reg rst_meta_ff;
   reg rst_n_ff;

   // Two-stage release of the asynchronous reset
   // Only the second stage fans out; nothing else reads the first
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   // ----------------------------------------
   // Millisecond and tone enables
   // ----------------------------------------
   // Counts are worked out as integers, then cut to counter width on purpose
   localparam integer TICK_LAST_I = `LBS_TICK_CYC - 1;
   localparam integer HALF_LAST_I = `LBS_TONE_HALF_CYC - 1;
   localparam [16:0] TICK_LAST = TICK_LAST_I[16:0];
   localparam [15:0] HALF_LAST = HALF_LAST_I[15:0];
   reg [16:0] tick_cnt_ff;
   reg tick_ff;
   reg [15:0] tone_cnt_ff;
   reg tone_ff;

   // 1 kHz tick and 2 kHz tone square wave
   always @(posedge clk_in or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         tick_cnt_ff <= 17'h0_0000;
         tick_ff <= 1'b0;
         tone_cnt_ff <= 16'h0000;
         tone_ff <= 1'b0;
      end else begin
         tick_ff <= (tick_cnt_ff == TICK_LAST);
         if (tick_cnt_ff == TICK_LAST) begin
            tick_cnt_ff <= 17'h0_0000;
         end else begin
            tick_cnt_ff <= tick_cnt_ff + 17'h0_0001;
         end
         if (tone_cnt_ff == HALF_LAST) begin
            tone_cnt_ff <= 16'h0000;
            tone_ff <= ~tone_ff;
         end else begin
            tone_cnt_ff <= tone_cnt_ff + 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // Option capture through the shared converter
   // ----------------------------------------
   localparam [1:0] CAP_START = 2'h0;
   localparam [1:0] CAP_WAIT = 2'h1;
   localparam [1:0] CAP_THERM = 2'h2;
   localparam [1:0] CAP_TWAIT = 2'h3;
   reg [1:0] cap_state_ff;
   reg [1:0] nxt_cap_state;
   reg opt_valid_ff;
   reg [3:0] nxt_option;

   // Threshold decode of the configuration reading
   always @* begin
      if (adc_data_in < `LBS_TH_PULLDOWN) begin
         nxt_option = `LBS_OPT_PULLDOWN;
      end else if (adc_data_in >= `LBS_TH_PULLUP) begin
         nxt_option = `LBS_OPT_PULLUP;
      end else begin
         nxt_option = `LBS_OPT_PULLDOWN;
      end
   end

   // Capture sequencer next state
   always @* begin
      nxt_cap_state = cap_state_ff;
      case (cap_state_ff)
         CAP_START: nxt_cap_state = CAP_WAIT;
         CAP_WAIT: begin
            if (adc_done_in) begin
               nxt_cap_state = CAP_THERM;
            end
         end
         CAP_THERM: nxt_cap_state = CAP_TWAIT;
         CAP_TWAIT: begin
            if (adc_done_in) begin
               nxt_cap_state = CAP_THERM;
            end
         end
         default: nxt_cap_state = CAP_START;
      endcase
   end

   // Config read once, then converter serves the thermistor only
   // Done pulses outside the two wait states are ignored
   always @(posedge clk_in or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         cap_state_ff <= CAP_START;
         opt_valid_ff <= 1'b0;
         led_option_out <= `LBS_OPT_PULLDOWN;
         adc_start_out <= 1'b0;
         adc_channel_out <= `LBS_CH_CONFIG;
         thermistor_sense_out <= 10'h000;
      end else begin
         cap_state_ff <= nxt_cap_state;
         adc_start_out <= (cap_state_ff == CAP_START) || (cap_state_ff == CAP_THERM);
         if (cap_state_ff == CAP_START) begin
            adc_channel_out <= `LBS_CH_CONFIG;
         end else if (cap_state_ff == CAP_THERM) begin
            adc_channel_out <= `LBS_CH_THERM;
         end
         if (cap_state_ff == CAP_WAIT && adc_done_in && !opt_valid_ff) begin
            led_option_out <= nxt_option;
            opt_valid_ff <= 1'b1;
         end
         if (cap_state_ff == CAP_TWAIT && adc_done_in) begin
            thermistor_sense_out <= adc_data_in;
         end
      end
   end

   // ----------------------------------------
   // State tracking and pattern timers
   // ----------------------------------------
   reg [2:0] prev_state_ff;
   wire enter_state = (op_state_in != prev_state_ff);
   wire [15:0] slow_phase;
   wire [15:0] fast_phase;
   wire [15:0] warn_phase;
   reg [15:0] beep_cnt_ff;

   // Previous state for entry detection
   always @(posedge clk_in or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         prev_state_ff <= `LBS_ST_STANDBY;
      end else begin
         prev_state_ff <= op_state_in;
      end
   end

   // Slow blink phase restarts on state entry
   lbs_ms_timer u_slow (
      .clk_in(clk_in),
      .rst_n_in(rst_n_ff),
      .tick_in(tick_ff),
      .clear_in(enter_state),
      .period_in(16'd`LBS_SLOW_PERIOD_MS),
      .phase_ff_out(slow_phase)
   );

   // Fast blink phase, shared by red LED and warning tone
   lbs_ms_timer u_fast (
      .clk_in(clk_in),
      .rst_n_in(rst_n_ff),
      .tick_in(tick_ff),
      .clear_in(enter_state),
      .period_in(16'd`LBS_FAST_PERIOD_MS),
      .phase_ff_out(fast_phase)
   );

   // Sixty-second warning cycle
   lbs_ms_timer u_warn (
      .clk_in(clk_in),
      .rst_n_in(rst_n_ff),
      .tick_in(tick_ff),
      .clear_in(enter_state || (op_state_in != `LBS_ST_WARNING)),
      .period_in(16'd`LBS_WARN_CYCLE_MS),
      .phase_ff_out(warn_phase)
   );

   wire slow_on = (slow_phase < 16'd`LBS_SLOW_ON_MS);
   wire fast_on = (fast_phase < 16'd`LBS_FAST_ON_MS);

   // Transfer-start beep length, armed on entry to transfer
   // Tone phase runs free, so the first audible edge trails entry by under 0.25 ms
   always @(posedge clk_in or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         beep_cnt_ff <= 16'h0000;
      end else if (enter_state && op_state_in == `LBS_ST_TRANSFER) begin
         beep_cnt_ff <= 16'd`LBS_BEEP_MS;
      end else if (op_state_in != `LBS_ST_TRANSFER) begin
         beep_cnt_ff <= 16'h0000;
      end else if (tick_ff && beep_cnt_ff != 16'h0000) begin
         beep_cnt_ff <= beep_cnt_ff - 16'h0001;
      end
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   reg nxt_red;
   reg nxt_green;
   reg nxt_buzz_en;
   wire standby_lit = opt_valid_ff && (led_option_out < `LBS_OPT_FIRST_DARK);

   // Lamp and buzzer pattern by operating state
   always @* begin
      nxt_red = 1'b0;
      nxt_green = 1'b0;
      nxt_buzz_en = 1'b0;
      case (op_state_in)
         `LBS_ST_STANDBY: begin
            nxt_red = standby_lit;
            nxt_green = standby_lit;
         end
         `LBS_ST_TRANSFER: begin
            nxt_green = slow_on;
            nxt_buzz_en = (beep_cnt_ff != 16'h0000);
         end
         `LBS_ST_COMPLETE: nxt_green = 1'b1;
         `LBS_ST_FAULT: nxt_red = 1'b1;
         `LBS_ST_WARNING: begin
            nxt_red = fast_on;
            nxt_buzz_en = fast_on && (warn_phase < 16'd`LBS_WARN_AUDIBLE_MS);
         end
         default: begin
            nxt_red = 1'b0;
            nxt_green = 1'b0;
         end
      endcase
   end

   // Registered pins; spares held inactive
   // A silent buzzer is held low rather than left at the tone level
   always @(posedge clk_in or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         red_indicator_out <= 1'b0;
         green_indicator_out <= 1'b0;
         buzzer_out <= 1'b0;
         spare_indicator_c_out <= 1'b0;
         spare_indicator_d_out <= 1'b0;
      end else begin
         red_indicator_out <= nxt_red;
         green_indicator_out <= nxt_green;
         buzzer_out <= nxt_buzz_en & tone_ff;
         spare_indicator_c_out <= 1'b0;
         spare_indicator_d_out <= 1'b0;
      end
   end

endmodule

// file: hdl/lbs_consts.vh
// Constants for the LED and buzzer status indicator.
// Assumes a 125 MHz system clock; included by the design files.
`ifndef LBS_CONSTS_VH
`define LBS_CONSTS_VH

// ----------------------------------------
// Clock and time base
// ----------------------------------------
`define LBS_CLK_HZ 125000000
`define LBS_TICK_HZ 1000
`define LBS_TICK_CYC (`LBS_CLK_HZ / `LBS_TICK_HZ)
`define LBS_TONE_HZ 2000
`define LBS_TONE_HALF_CYC (`LBS_CLK_HZ / (2 * `LBS_TONE_HZ))

// ----------------------------------------
// Pattern times in milliseconds
// ----------------------------------------
`define LBS_SLOW_ON_MS 1000
`define LBS_SLOW_PERIOD_MS 2000
`define LBS_FAST_ON_MS 400
`define LBS_FAST_PERIOD_MS 1200
`define LBS_BEEP_MS 400
`define LBS_BEEP_LATENCY_MS 500
`define LBS_WARN_AUDIBLE_MS 30000
`define LBS_WARN_CYCLE_MS 60000

// ----------------------------------------
// Operating states
// ----------------------------------------
`define LBS_ST_STANDBY 3'h0
`define LBS_ST_TRANSFER 3'h1
`define LBS_ST_COMPLETE 3'h2
`define LBS_ST_FAULT 3'h3
`define LBS_ST_WARNING 3'h4

// ----------------------------------------
// Option decode thresholds on the 10-bit reading
// ----------------------------------------
`define LBS_ADC_W 10
`define LBS_CH_CONFIG 2'h0
`define LBS_CH_THERM 2'h1
`define LBS_OPT_PULLDOWN 4'h0
`define LBS_OPT_PULLUP 4'h5
`define LBS_OPT_FIRST_DARK 4'h5
`define LBS_TH_PULLDOWN 10'h0_040
`define LBS_TH_PULLUP 10'h3_C0
`endif

// file: hdl/lbs_ms_timer.v
// Millisecond phase counter with a programmable period.
// Assumes a one-cycle tick enable at 1 kHz from the parent.
`timescale 1ns/1ps
`include "lbs_consts.vh"

module lbs_ms_timer (
   // Clock and reset
   input wire clk_in,
   input wire rst_n_in,
   // Control
   input wire tick_in,
   input wire clear_in,
   input wire [15:0] period_in,
   // Phase
   output reg [15:0] phase_ff_out
);

   // Counts ticks, wraps at period, restarts on clear
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_ff_out <= 16'h0000;
      end else if (clear_in) begin
         phase_ff_out <= 16'h0000;
      end else if (tick_in) begin
         if (phase_ff_out >= period_in - 16'h0001) begin
            phase_ff_out <= 16'h0000;
         end else begin
            phase_ff_out <= phase_ff_out + 16'h0001;
         end
      end
   end

endmodule

// file: testbench/lbs_indicator_asserts.sv
// Port checker for the status indicator.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
module lbs_indicator_asserts (
   // Clock and reset
   input logic clk_in,
   input logic arst_n_in,
   // Inputs
   input logic [2:0] op_state_in,
   input logic adc_done_in,
   input logic [9:0] adc_data_in,
   // Outputs
   input logic adc_start_out,
   input logic [1:0] adc_channel_out,
   input logic [9:0] thermistor_sense_out,
   input logic red_indicator_out,
   input logic green_indicator_out,
   input logic buzzer_out,
   input logic spare_indicator_c_out,
   input logic spare_indicator_d_out,
   input logic [3:0] led_option_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   int hi_cnt_ff;
   // Length of the current high stretch of the buzzer
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) hi_cnt_ff <= 0;
      else hi_cnt_ff <= buzzer_out ? hi_cnt_ff + 1 : 0;
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_spare; !spare_indicator_c_out && !spare_indicator_d_out; endproperty
   a_spare: assert property (p_spare) else $error("spare lamp on");
   property p_pulse; adc_start_out |=> !adc_start_out; endproperty
   a_pulse: assert property (p_pulse) else $error("start too long");
   property p_chan; adc_channel_out == 2'h1 |=> adc_channel_out == 2'h1; endproperty
   a_chan: assert property (p_chan) else $error("config read again");
   property p_therm;
      adc_done_in && adc_channel_out == 2'h1 |=> thermistor_sense_out == $past(adc_data_in);
   endproperty
   a_therm: assert property (p_therm) else $error("reading lost");
   property p_next; adc_done_in |-> ##[1:2] adc_start_out; endproperty
   a_next: assert property (p_next) else $error("no next start");
   property p_opt; led_option_out != 4'h0 |=> $stable(led_option_out); endproperty
   a_opt: assert property (p_opt) else $error("option changed");
   property p_fault;
      (op_state_in == 3'h3)[*4] |-> red_indicator_out && !green_indicator_out && !buzzer_out;
   endproperty
   a_fault: assert property (p_fault) else $error("fault lamps");
   property p_done;
      (op_state_in == 3'h2)[*4] |-> green_indicator_out && !red_indicator_out;
   endproperty
   a_done: assert property (p_done) else $error("complete lamps");
   property p_xfer;
      op_state_in != 3'h1 ##1 (op_state_in == 3'h1)[*3] |-> green_indicator_out
         && !red_indicator_out;
   endproperty
   a_xfer: assert property (p_xfer) else $error("transfer lamps");
   property p_warn;
      op_state_in != 3'h4 ##1 (op_state_in == 3'h4)[*3] |-> red_indicator_out
         && !green_indicator_out;
   endproperty
   a_warn: assert property (p_warn) else $error("warning lamps");
   property p_align;
      (op_state_in == 3'h4)[*3] ##1 (op_state_in == 3'h4 && buzzer_out) |-> red_indicator_out;
   endproperty
   a_align: assert property (p_align) else $error("tone without red");
   property p_tone; hi_cnt_ff <= 31250; endproperty
   a_tone: assert property (p_tone) else $error("tone half too long");
   property p_stby;
      (op_state_in == 3'h0 && led_option_out == 4'h5)[*2] |-> !red_indicator_out
         && !green_indicator_out;
   endproperty
   a_stby: assert property (p_stby) else $error("standby lamps lit");
   // Main scenarios reached
   c_therm: cover property (adc_done_in && adc_channel_out == 2'h1);
   c_warn: cover property (op_state_in == 3'h4 && $rose(buzzer_out));
   c_beep: cover property (op_state_in == 3'h1 && buzzer_out);
endmodule
bind lbs_indicator lbs_indicator_asserts u_chk (.clk_in, .arst_n_in, .op_state_in,
   .adc_done_in, .adc_data_in, .adc_start_out, .adc_channel_out, .thermistor_sense_out,
   .red_indicator_out, .green_indicator_out, .buzzer_out, .spare_indicator_c_out,
   .spare_indicator_d_out, .led_option_out);

// file: testbench/lbs_adc_model.sv
// Shared converter model: answers each start with one done pulse.
// Assumes start is a one-cycle pulse and the channel stands meanwhile.
`timescale 1ns/1ps
module lbs_adc_model (
   // Clock and control
   input wire clk_in,
   input wire start_in,
   input wire [1:0] ch_in,
   input wire slow_in,
   input wire [9:0] cfg_in,
   // Answer
   output reg done_out,
   output reg [9:0] data_out,
   output reg [9:0] therm_out
);
   int wait_ff = 0;
   initial begin
      done_out = 1'b0;
      data_out = 10'h2AA;
      therm_out = 10'h155;
   end
   // Wait short or long, then hand over the selected input's reading
   always @(posedge clk_in) begin
      done_out <= 1'b0;
      data_out <= ~data_out;
      if (start_in) begin
         wait_ff <= slow_in ? 20 : 1;
      end else if (wait_ff > 0) begin
         wait_ff <= wait_ff - 1;
         if (wait_ff == 1) begin
            done_out <= 1'b1;
            data_out <= (ch_in == 2'h0) ? cfg_in : therm_out + 10'h001;
            if (ch_in != 2'h0) therm_out <= therm_out + 10'h001;
         end
      end
   end
endmodule

// file: testbench/led_buzzer_status_indicator_tb_top.sv
// Self-checking bench for the status indicator.
// Assumes the converter model on the converter side; lamps observed directly.
`timescale 1ns/1ps
`include "lbs_consts.vh"
module led_buzzer_status_indicator_tb_top;
   typedef struct packed {logic [9:0] cfg; logic [3:0] opt; logic lit;} lbs_row_t;
   lbs_row_t rows [6] = '{{10'h000, 4'h0, 1'b1}, {10'h03F, 4'h0, 1'b1},
      {10'h040, 4'h0, 1'b1}, {10'h3BF, 4'h0, 1'b1}, {10'h3C0, 4'h5, 1'b0},
      {10'h3FF, 4'h5, 1'b0}};
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic slow = 1'b0;
   logic [2:0] op_state_in = 3'h0;
   logic [9:0] cfg = 10'h000;
   logic adc_done_in, adc_start_out, red_indicator_out, green_indicator_out, buzzer_out;
   logic spare_indicator_c_out, spare_indicator_d_out;
   logic [9:0] adc_data_in, thermistor_sense_out, therm;
   logic [1:0] adc_channel_out;
   logic [3:0] led_option_out;
   int failures = 0;
   int n_checks = 0;
   int n = 0;
   // Clock and parts
   always #4 clk_in = ~clk_in;
   lbs_indicator u_dut (.clk_in, .arst_n_in, .op_state_in, .adc_done_in, .adc_data_in,
      .adc_start_out, .adc_channel_out, .thermistor_sense_out, .red_indicator_out,
      .green_indicator_out, .buzzer_out, .spare_indicator_c_out, .spare_indicator_d_out,
      .led_option_out);
   lbs_adc_model u_adc (.clk_in, .start_in(adc_start_out), .ch_in(adc_channel_out),
      .slow_in(slow), .cfg_in(cfg), .done_out(adc_done_in), .data_out(adc_data_in),
      .therm_out(therm));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_in);
   endtask
   task automatic wait_buz(input logic lvl, input int lim);
      n = 0;
      while (buzzer_out !== lvl && n < lim) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic do_reset(input logic [9:0] c);
      arst_n_in = 1'b0;
      op_state_in = 3'h0;
      cfg = c;
      cyc(4);
      chk({red_indicator_out, green_indicator_out, buzzer_out, spare_indicator_c_out,
         spare_indicator_d_out, adc_start_out, adc_channel_out, led_option_out}, 16'h0000);
      arst_n_in = 1'b1;
      n = 0;
      while (adc_channel_out !== 2'h1 && n < 200) begin
         cyc(1);
         n++;
      end
      cyc(3);
   endtask
   task automatic st(input logic [2:0] s, input logic [1:0] e);
      op_state_in = s;
      cyc(3);
      chk({spare_indicator_c_out, spare_indicator_d_out, red_indicator_out,
         green_indicator_out}, {2'b00, e});
   endtask
   task automatic final_report;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Option rows, then state lamps, warning tone and transfer beep
   initial begin
      for (int i = 0; i < 6; i++) begin
         slow = i[0];
         do_reset(rows[i].cfg);
         chk(led_option_out, rows[i].opt);
         chk({red_indicator_out, green_indicator_out}, {2{rows[i].lit}});
         cyc(80);
         chk(led_option_out, rows[i].opt);
         n = 0;
         while (adc_start_out !== 1'b1 && n < 50) begin
            cyc(1);
            n++;
         end
         chk(thermistor_sense_out, therm);
         $display("option row %0d finished", i);
      end
      st(3'h2, 2'b01);
      st(3'h3, 2'b10);
      chk(buzzer_out, 1'b0);
      $display("state lamps finished");
      st(3'h4, 2'b10);
      wait_buz(1'b1, 31300);
      chk(n < 31300, 1'b1);
      wait_buz(1'b0, 31300);
      wait_buz(1'b1, 31300);
      chk(16'(n), 16'(`LBS_TONE_HALF_CYC));
      chk(red_indicator_out, 1'b1);
      st(3'h3, 2'b10);
      chk(buzzer_out, 1'b0);
      $display("warning tone finished");
      st(3'h1, 2'b01);
      chk(buzzer_out, 1'b1);
      $display("transfer beep finished");
      final_report;
   end
   // Watchdog: the tests need about 96k cycles
   initial begin
      #1_200_000;
      failures++;
      final_report;
   end
endmodule
